// file: hw/rsc_pkg.sv
package rsc_pkg;

  // clock and pin timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int PIN_GLITCH_NS = 12;
  localparam int PIN_GLITCH_RAW = (PIN_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_GLITCH_CYC = (PIN_GLITCH_RAW < 1) ? 1 : PIN_GLITCH_RAW;
  localparam int PIN_MIN_CYC = 3;
  localparam logic [1:0] PIN_MIN_CNT = 2'(PIN_MIN_CYC);
  localparam logic [1:0] PIN_GLITCH_CNT = 2'(PIN_GLITCH_CYC);

  // reset delay in internal oscillator cycles
  localparam int RST_DLY_SHORT = 66;
  localparam int RST_DLY_LONG = 5000;
  localparam int CNT_W = 13;

  // debug line break detection
  localparam int DBG_BIT_CYC = 16;
  localparam logic [4:0] DBG_BIT_LAST = 5'(DBG_BIT_CYC - 1);
  localparam logic [3:0] DBG_BREAK_BITS = 4'h9;

  // register byte offsets
  localparam logic [3:0] OFF_CAUSE = 4'h0;
  localparam logic [3:0] OFF_CTRL = 4'h4;
  localparam logic [3:0] OFF_DBG = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hC;

  // field positions and reset values
  localparam int CAUSE_POS = 4;
  localparam int DBG_RST_BIT = 0;
  localparam logic [3:0] CTRL_RST = 4'hB;
  localparam logic [3:0] CAUSE_RST = 4'h0;

  // cpu restart vector location
  localparam logic [15:0] RST_VEC_HI = 16'h0002;
  localparam logic [15:0] RST_VEC_LO = 16'h0003;

  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_HOLD, ST_PIN_WAIT} rsc_state_t;

  typedef struct packed {
    logic por;
    logic stop;
    logic wdt;
    logic pin_reset_flag;
  } rsc_cause_t;

  typedef struct packed {
    logic pin_rst_en;
    logic xtal_en;
    logic brownout_always_on_option;
    logic watchdog_reset_option;
  } rsc_ctrl_t;

endpackage

// file: hw/rsc_reset_ctrl.sv
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module rsc_reset_ctrl #(
  parameter int RST_DLY_LONG_CYC = rsc_pkg::RST_DLY_LONG
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic brownout_detect,
  input wire logic supply_above_por,
  input wire logic wdt_timeout,
  input wire logic stop_exec,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_n,
  input wire logic gpio_drive_low,
  input wire logic debug_pin,
  input wire logic dbg_frame_err,
  input wire logic dbg_tx_collision,
  input wire logic [7:0] wake_pins,
  input wire logic [7:0] wake_enable,
  output logic cpu_rst_n,
  output logic sys_rst_n,
  output logic stop_mode,
  output logic port_capture_en,
  output logic osc_force_int,
  output logic fetch_vector,
  output logic wdt_irq,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import rsc_pkg::*;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: bo, por_ok, pin, dbg, wake[7:0]
  logic [11:0] sync1_q;
  logic [11:0] sync2_q;
  logic [7:0] wake_prev_q;
  logic bo_s, por_ok_s, pin_s, dbg_s;
  logic [7:0] wake_s;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // idle levels: debug and pin high, supply good, no brown-out, wakes low
      sync1_q <= 12'hE00;
      sync2_q <= 12'hE00;
      wake_prev_q <= 8'h00;
    end else begin
      sync1_q <= {debug_pin, rst_pin_i, supply_above_por, brownout_detect, wake_pins};
      sync2_q <= sync1_q;
      wake_prev_q <= sync2_q[7:0];
    end
  end

  assign {dbg_s, pin_s, por_ok_s, bo_s} = sync2_q[11:8];
  assign wake_s = sync2_q[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // pin filter and debug break detector
  rsc_ctrl_t ctrl_q, ctrl_d;
  rsc_state_t state_q, state_d;
  logic [1:0] pin_cnt_q, pin_cnt_d;
  logic [4:0] dbg_div_q, dbg_div_d;
  logic [3:0] dbg_bits_q, dbg_bits_d;
  logic pin_low, ext_evt, brk_evt, bit_tick;
  logic [1:0] pin_thr;

  always_comb begin
    // own drive masks the input; stop mode uses the short glitch filter
    pin_low = !pin_s && ctrl_q.pin_rst_en && rst_pin_oe_n;
    pin_thr = (state_q == ST_STOP) ? PIN_GLITCH_CNT : PIN_MIN_CNT;
    pin_cnt_d = pin_cnt_q;
    if (!pin_low) begin
      pin_cnt_d = 2'h0;
    end else if (pin_cnt_q != pin_thr) begin
      pin_cnt_d = pin_cnt_q + 2'h1;
    end
    ext_evt = pin_low && (pin_cnt_q == pin_thr - 2'h1);
    bit_tick = (dbg_div_q == DBG_BIT_LAST);
    dbg_div_d = bit_tick ? 5'h00 : dbg_div_q + 5'h01;
    dbg_bits_d = dbg_bits_q;
    if (bit_tick) begin
      if (dbg_s) begin
        dbg_bits_d = 4'h0;
      end else if (dbg_bits_q != DBG_BREAK_BITS) begin
        dbg_bits_d = dbg_bits_q + 4'h1;
      end
    end
    brk_evt = bit_tick && !dbg_s && (dbg_bits_q == DBG_BREAK_BITS - 4'h1);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_cnt_q <= 2'h0;
      dbg_div_q <= 5'h00;
      dbg_bits_q <= 4'h0;
    end else begin
      pin_cnt_q <= pin_cnt_d;
      dbg_div_q <= dbg_div_d;
      dbg_bits_q <= dbg_bits_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  rsc_cause_t cause_q, cause_d, pend_q, pend_d, clr_cause;
  logic [CNT_W-1:0] cnt_q, cnt_d, dly_last;
  logic sys_q, sys_d, irq_pend_q, irq_pend_d, dbg_req_q, dbg_req_d;
  logic bo_act, dbg_evt, wdt_rst, wake_evt, sys_src, pin_ok, finish;
  logic rd_cause, dbg_wr;
  logic cpu_rst_n_d, sys_rst_n_d, oe_n_d, stop_d, cap_d, osc_d, fetch_d, irq_d;

  function automatic rsc_cause_t merge_cause(rsc_cause_t c, rsc_cause_t p);
    rsc_cause_t r;
    r = c;
    if (p.wdt || p.stop) begin
      r = '{por: 1'b0, stop: p.stop, wdt: p.wdt, pin_reset_flag: c.pin_reset_flag};
    end
    if (p.por) begin
      // power-on clears stop, watchdog and earlier pin flags (a queued pin flag stays), so it outranks a queued watchdog
      r = '{por: 1'b1, stop: 1'b0, wdt: 1'b0, pin_reset_flag: 1'b0};
    end
    if (p.pin_reset_flag) begin
      r.pin_reset_flag = 1'b1;
    end
    return r;
  endfunction

  always_comb begin
    bo_act = (bo_s || !por_ok_s) && (state_q != ST_STOP || ctrl_q.brownout_always_on_option);
    dbg_evt = brk_evt || dbg_frame_err || dbg_tx_collision || dbg_req_q;
    wdt_rst = wdt_timeout && ctrl_q.watchdog_reset_option && state_q != ST_STOP;
    wake_evt = |((wake_s ^ wake_prev_q) & wake_enable);
    sys_src = bo_act || dbg_evt || wdt_rst || (ext_evt && state_q != ST_PIN_WAIT);
    dly_last = ctrl_q.xtal_en ? CNT_W'(RST_DLY_LONG_CYC - 1) : CNT_W'(RST_DLY_SHORT - 1);
    pin_ok = pin_s || !ctrl_q.pin_rst_en;
    clr_cause = rd_cause ? rsc_cause_t'(4'h0) : cause_q;
    state_d = state_q;
    cnt_d = cnt_q;
    sys_d = sys_q;
    pend_d = pend_q;
    irq_pend_d = irq_pend_q;
    cause_d = clr_cause;
    dbg_req_d = dbg_req_q || dbg_wr;
    irq_d = 1'b0;
    fetch_d = 1'b0;
    osc_d = 1'b0;
    finish = 1'b0;
    if (sys_src && state_q != ST_PIN_WAIT) begin
      // a new source, or one still present, restarts one full delay
      state_d = ST_HOLD;
      cnt_d = '0;
      sys_d = 1'b1;
      irq_pend_d = 1'b0;
      dbg_req_d = dbg_wr;
      if (!sys_q || state_q == ST_RUN || state_q == ST_STOP) begin
        pend_d = rsc_cause_t'(4'h0);
      end
      if (bo_act || dbg_evt) begin
        pend_d.por = 1'b1;
      end
      if (wdt_rst) begin
        pend_d.wdt = 1'b1;
      end
      if (ext_evt) begin
        pend_d.pin_reset_flag = 1'b1;
      end
    end else begin
      case (state_q)
        ST_RUN: begin
          if (wdt_timeout) begin
            irq_d = 1'b1;
            cause_d.wdt = 1'b1;
          end else if (stop_exec) begin
            state_d = ST_STOP;
          end
        end
        ST_STOP: begin
          if (wdt_timeout) begin
            state_d = ST_HOLD;
            cnt_d = '0;
            sys_d = 1'b0;
            pend_d = '{por: 1'b0, stop: 1'b1, wdt: 1'b1, pin_reset_flag: 1'b0};
            irq_pend_d = !ctrl_q.watchdog_reset_option;
          end else if (wake_evt) begin
            state_d = ST_HOLD;
            cnt_d = '0;
            sys_d = 1'b0;
            pend_d = '{por: 1'b0, stop: 1'b1, wdt: 1'b0, pin_reset_flag: 1'b0};
            irq_pend_d = 1'b0;
          end
        end
        ST_HOLD: begin
          dbg_req_d = dbg_wr;
          if (cnt_q == dly_last) begin
            // system reset lets go of the pin first, then checks it
            if (sys_q && ctrl_q.pin_rst_en) begin
              state_d = ST_PIN_WAIT;
            end else begin
              finish = 1'b1;
            end
          end else begin
            cnt_d = cnt_q + CNT_W'(1);
          end
        end
        ST_PIN_WAIT: begin
          if (pin_ok) begin
            finish = 1'b1;
          end
        end
        default: begin
          state_d = ST_RUN;
        end
      endcase
    end
    if (finish) begin
      state_d = ST_RUN;
      cause_d = merge_cause(clr_cause, pend_q);
      fetch_d = 1'b1;
      osc_d = !sys_q;
      irq_d = irq_pend_q;
      irq_pend_d = 1'b0;
    end
    cpu_rst_n_d = (state_d == ST_RUN) || (state_d == ST_STOP);
    sys_rst_n_d = !(sys_d && !cpu_rst_n_d);
    oe_n_d = !((state_d == ST_HOLD && sys_d) || (!ctrl_q.pin_rst_en && gpio_drive_low));
    stop_d = (state_d == ST_STOP);
    cap_d = (state_d == ST_RUN);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // power-up behaves as a brown-out release
      state_q <= ST_HOLD;
      cnt_q <= '0;
      sys_q <= 1'b1;
      pend_q <= '{por: 1'b1, stop: 1'b0, wdt: 1'b0, pin_reset_flag: 1'b0};
      irq_pend_q <= 1'b0;
      cause_q <= rsc_cause_t'(CAUSE_RST);
      dbg_req_q <= 1'b0;
      cpu_rst_n <= 1'b0;
      sys_rst_n <= 1'b0;
      rst_pin_o <= 1'b0;
      rst_pin_oe_n <= 1'b0;
      stop_mode <= 1'b0;
      port_capture_en <= 1'b0;
      osc_force_int <= 1'b0;
      fetch_vector <= 1'b0;
      wdt_irq <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sys_q <= sys_d;
      pend_q <= pend_d;
      irq_pend_q <= irq_pend_d;
      cause_q <= cause_d;
      dbg_req_q <= dbg_req_d;
      cpu_rst_n <= cpu_rst_n_d;
      sys_rst_n <= sys_rst_n_d;
      rst_pin_o <= 1'b0;
      rst_pin_oe_n <= oe_n_d;
      stop_mode <= stop_d;
      port_capture_en <= cap_d;
      osc_force_int <= osc_d;
      fetch_vector <= fetch_d;
      wdt_irq <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then answer
  logic wait_q, wait_d;
  logic [31:0] rdata_d;
  logic acc, wr_ok;

  always_comb begin
    acc = (avs_read || avs_write) && !wait_q;
    wr_ok = acc && avs_write && avs_byteenable[0];
    rd_cause = acc && avs_read && avs_address == OFF_CAUSE;
    dbg_wr = wr_ok && avs_address == OFF_DBG && avs_writedata[DBG_RST_BIT];
    ctrl_d = ctrl_q;
    if (wr_ok && avs_address == OFF_CTRL) begin
      ctrl_d = rsc_ctrl_t'(avs_writedata[3:0]);
    end
    wait_d = !((avs_read || avs_write) && wait_q);
    rdata_d = 32'h0000_0000;
    if (avs_read && wait_q) begin
      case (avs_address)
        OFF_CAUSE: rdata_d[CAUSE_POS+:4] = cause_q;
        OFF_CTRL: rdata_d[3:0] = ctrl_q;
        OFF_DBG: rdata_d[DBG_RST_BIT] = dbg_req_q;
        OFF_STATUS: rdata_d[3:0] = {pin_s, sys_q, stop_mode, !cpu_rst_n};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 1'b1;
      ctrl_q <= rsc_ctrl_t'(CTRL_RST);
      avs_readdata <= 32'h0000_0000;
    end else begin
      wait_q <= wait_d;
      ctrl_q <= ctrl_d;
      avs_readdata <= rdata_d;
    end
  end

  assign avs_waitrequest = wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_bo_holds_cpu: assert property (
    bo_act |=> !cpu_rst_n ##1 !cpu_rst_n)
    else $error("brown-out did not hold the cpu in reset");
  a_por_flag_exit: assert property (
    finish && pend_q.por |=> cause_q.por && !cause_q.stop && fetch_vector)
    else $error("power-on flag not set at end of reset");
  a_bo_masked_stop: assert property (
    state_q == ST_STOP && !ctrl_q.brownout_always_on_option && !dbg_evt && !ext_evt
      && !wdt_timeout && !wake_evt |=> state_q == ST_STOP)
    else $error("brown-out acted in stop with always-on option clear");
  a_wdt_irq_mode: assert property (
    state_q == ST_RUN && wdt_timeout && !ctrl_q.watchdog_reset_option && !sys_src
      |=> wdt_irq && cpu_rst_n && cause_q.wdt)
    else $error("watchdog interrupt mode did not raise interrupt");
  a_wdt_reset_mode: assert property (
    state_q == ST_RUN && wdt_timeout && ctrl_q.watchdog_reset_option
      |=> state_q == ST_HOLD && pend_q.wdt && !cpu_rst_n)
    else $error("watchdog reset mode did not start reset");
  a_pin_three_low: assert property (
    (state_q == ST_RUN && pin_low)[*3] |=> state_q == ST_HOLD && pend_q.pin_reset_flag)
    else $error("three low pin samples did not start reset");
  a_pin_wait_low: assert property (
    state_q == ST_PIN_WAIT && !pin_s |=> !cpu_rst_n && rst_pin_oe_n)
    else $error("left reset while pin still low");
  a_drive_in_hold: assert property (
    state_q == ST_HOLD && sys_q |-> !rst_pin_oe_n && !rst_pin_o && !sys_rst_n)
    else $error("reset pin not driven during system reset");
  a_count_restart: assert property (
    state_q == ST_HOLD && sys_src |=> cnt_q == '0 && state_q == ST_HOLD)
    else $error("reset delay not restarted by new source");
  a_stop_entry: assert property (
    state_q == ST_RUN && stop_exec && !sys_src && !wdt_timeout |=> stop_mode && !port_capture_en)
    else $error("stop instruction did not enter stop mode");
  a_recovery_exit: assert property (
    finish && !sys_q |=> osc_force_int && cause_q.stop && sys_rst_n && fetch_vector)
    else $error("stop recovery exit incomplete");
  a_wake_recovery: assert property (
    state_q == ST_STOP && wake_evt && !sys_src
      |=> state_q == ST_HOLD && !sys_q && !cpu_rst_n && sys_rst_n)
    else $error("wake pin change did not start recovery");
  a_break_request: assert property (
    brk_evt && state_q == ST_RUN |=> state_q == ST_HOLD && pend_q.por)
    else $error("debug break did not request reset");
  a_debug_bit_clears: assert property (
    state_q == ST_HOLD && !dbg_wr |=> !dbg_req_q)
    else $error("debug reset bit not cleared during reset");
  a_read_clears: assert property (
    rd_cause && !finish && !(state_q == ST_RUN && wdt_timeout) |=> cause_q == 4'h0)
    else $error("cause read did not clear flags");

endmodule

// file: test/rsc_far_side.sv
`timescale 1ns/1ps
module rsc_far_side (
  input wire logic pin_pull_low,
  input wire logic dbg_hold_low,
  input wire logic rst_pin_oe_n,
  input wire logic rst_pin_o,
  output logic rst_pin_wire,
  output logic debug_line
);
  // pull-up on the pin: low only while one party pulls it
  assign rst_pin_wire = pin_pull_low ? 1'b0 : (!rst_pin_oe_n ? rst_pin_o : 1'b1);
  // debug line idles high; held low only for a break
  assign debug_line = !dbg_hold_low;
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rsc_pkg::*;
  localparam int LONG_N = 40;
  logic ref_clk, nrst, brownout_detect, wdt_timeout, stop_exec, dbg_frame_err, dbg_tx_collision;
  logic pin_pull, dbg_low, rst_pin_o, rst_pin_oe_n, rst_pin_wire, debug_line, por_ok, gpio_low;
  logic cpu_rst_n, sys_rst_n, stop_mode, port_capture_en, osc_force_int, fetch_vector, wdt_irq;
  logic avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [7:0] wake_pins;
  logic [31:0] avs_writedata, avs_readdata, q;
  int errors, n_checks, n_irq, n_fetch, n_osc, irq_bad, cyc;

  rsc_reset_ctrl #(.RST_DLY_LONG_CYC(LONG_N)) dut (.ref_clk(ref_clk), .nrst(nrst),
    .brownout_detect(brownout_detect), .supply_above_por(por_ok), .wdt_timeout(wdt_timeout),
    .stop_exec(stop_exec), .rst_pin_i(rst_pin_wire), .rst_pin_o(rst_pin_o),
    .rst_pin_oe_n(rst_pin_oe_n), .gpio_drive_low(gpio_low), .debug_pin(debug_line),
    .dbg_frame_err(dbg_frame_err), .dbg_tx_collision(dbg_tx_collision),
    .wake_pins(wake_pins), .wake_enable(8'h01), .cpu_rst_n(cpu_rst_n), .sys_rst_n(sys_rst_n),
    .stop_mode(stop_mode), .port_capture_en(port_capture_en), .osc_force_int(osc_force_int),
    .fetch_vector(fetch_vector), .wdt_irq(wdt_irq), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  rsc_far_side far (.pin_pull_low(pin_pull), .dbg_hold_low(dbg_low),
    .rst_pin_oe_n(rst_pin_oe_n), .rst_pin_o(rst_pin_o), .rst_pin_wire(rst_pin_wire),
    .debug_line(debug_line));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cyc++;
    if (wdt_irq === 1'b1) n_irq++;
    if (wdt_irq === 1'b1 && cpu_rst_n !== 1'b1) irq_bad++;
    if (fetch_vector === 1'b1) n_fetch++;
    if (osc_force_int === 1'b1) n_osc++;
    if (cyc == 40000) begin
      errors++;
      $display("[ERR] %0t run too long", $time);
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int n, input int lo, input int hi);
    n_checks++;
    if (n < lo || n > hi) begin
      errors++;
      $display("[ERR] %0t count %0d not in %0d..%0d", $time, n, lo, hi);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic pulse(input int k);
    if (k == 0) wdt_timeout <= 1'b1;
    if (k == 1) stop_exec <= 1'b1;
    if (k == 2) dbg_frame_err <= 1'b1;
    if (k == 3) dbg_tx_collision <= 1'b1;
    @(posedge ref_clk);
    wdt_timeout <= 1'b0;
    stop_exec <= 1'b0;
    dbg_frame_err <= 1'b0;
    dbg_tx_collision <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic pin_low(input int n);
    pin_pull <= 1'b1;
    repeat (n) @(posedge ref_clk);
    pin_pull <= 1'b0;
    @(posedge ref_clk);
  endtask
  // waits for cpu hold, counts it, then checks flags and vector fetch
  task automatic run_reset(input int lo, input int hi, input logic [3:0] cause, input logic sl);
    int n;
    int w;
    int f0;
    logic saw;
    n = 0;
    w = 0;
    saw = 1'b0;
    f0 = n_fetch;
    while (cpu_rst_n !== 1'b0 && w < 300) begin
      @(posedge ref_clk);
      w++;
    end
    while (cpu_rst_n !== 1'b1 && n < 6000) begin
      if (sys_rst_n === 1'b0) saw = 1'b1;
      @(posedge ref_clk);
      n++;
    end
    chk_rng(n, lo, hi);
    chk_val({31'h0, saw}, {31'h0, sl});
    bus(1'b0, OFF_CAUSE, 32'h0);
    chk_val(q & 32'hF0, {24'h0, cause, 4'h0});
    chk_val(n_fetch, f0 + 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    run_reset(66, 80, 4'h8, 1'b1);
    bus(1'b0, OFF_CAUSE, 32'h0);
    chk_val(q, 32'h0);
    bus(1'b1, OFF_CAUSE, 32'hFF);
    bus(1'b0, OFF_CAUSE, 32'h0);
    chk_val(q, 32'h0);
    bus(1'b0, OFF_CTRL, 32'h0);
    chk_val(q, {28'h0, CTRL_RST});
    bus(1'b0, OFF_STATUS, 32'h0);
    chk_val(q, 32'hC);
    bus(1'b0, 4'h2, 32'h0);
    chk_val(q, 32'h0);
    $display("power-on done");
  endtask
  task automatic t_wdt();
    pulse(0);
    repeat (3) @(posedge ref_clk);
    chk_val({31'h0, rst_pin_wire}, 32'h0);
    chk_val({31'h0, rst_pin_oe_n}, 32'h0);
    repeat (27) @(posedge ref_clk);
    pulse(0);
    run_reset(66, 80, 4'h2, 1'b1);
    bus(1'b1, OFF_CTRL, 32'hA);
    pulse(0);
    repeat (10) @(posedge ref_clk);
    chk_val({31'h0, cpu_rst_n}, 32'h1);
    chk_val(n_irq, 1);
    bus(1'b1, OFF_CTRL, 32'hF);
    pulse(0);
    run_reset(LONG_N, LONG_N + 14, 4'h2, 1'b1);
    bus(1'b1, OFF_CTRL, 32'hB);
    $display("watchdog done");
  endtask
  task automatic t_pin();
    pin_low(2);
    repeat (10) @(posedge ref_clk);
    chk_val({31'h0, cpu_rst_n}, 32'h1);
    pin_low(4);
    run_reset(66, 80, 4'h1, 1'b1);
    pin_pull <= 1'b1;
    repeat (200) @(posedge ref_clk);
    chk_val({31'h0, cpu_rst_n}, 32'h0);
    pin_pull <= 1'b0;
    run_reset(0, 6, 4'h1, 1'b1);
    bus(1'b1, OFF_CTRL, 32'h3);
    gpio_low <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk_val({30'h0, rst_pin_wire, cpu_rst_n}, 32'h1);
    gpio_low <= 1'b0;
    repeat (4) @(posedge ref_clk);
    bus(1'b1, OFF_CTRL, 32'hB);
    $display("reset pin done");
  endtask
  task automatic t_stop();
    int o0;
    pulse(1);
    chk_val({30'h0, stop_mode, port_capture_en}, 32'h2);
    wake_pins <= wake_pins ^ 8'h02;
    repeat (5) @(posedge ref_clk);
    chk_val({31'h0, stop_mode}, 32'h1);
    o0 = n_osc;
    wake_pins <= ~wake_pins;
    run_reset(66, 72, 4'h4, 1'b0);
    chk_val(n_osc, o0 + 1);
    chk_val({31'h0, port_capture_en}, 32'h1);
    pulse(1);
    pulse(0);
    run_reset(66, 72, 4'h6, 1'b0);
    bus(1'b1, OFF_CTRL, 32'hA);
    pulse(1);
    pulse(0);
    run_reset(66, 72, 4'h6, 1'b0);
    chk_val({n_irq[30:0], 1'b0} | irq_bad, 32'h4);
    bus(1'b1, OFF_CTRL, 32'h9);
    pulse(1);
    brownout_detect <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk_val({30'h0, cpu_rst_n, stop_mode}, 32'h3);
    brownout_detect <= 1'b0;
    wake_pins <= ~wake_pins;
    run_reset(66, 72, 4'h4, 1'b0);
    bus(1'b1, OFF_CTRL, 32'hB);
    pulse(1);
    pin_low(1);
    run_reset(66, 80, 4'h1, 1'b1);
    $display("stop recovery done");
  endtask
  task automatic t_debug();
    bus(1'b1, OFF_DBG, 32'h1);
    run_reset(66, 80, 4'h8, 1'b1);
    for (int k = 0; k < 4; k++) begin
      if (k == 0) pulse(2);
      if (k == 1) pulse(3);
      if (k == 2) begin
        dbg_low <= 1'b1;
        repeat (10 * DBG_BIT_CYC) @(posedge ref_clk);
        dbg_low <= 1'b0;
      end
      if (k == 3) pulse(1);
      if (k == 3) pulse(2);
      run_reset(k == 2 ? 30 : 66, 80, 4'h8, 1'b1);
    end
    brownout_detect <= 1'b1;
    por_ok <= 1'b0;
    repeat (100) @(posedge ref_clk);
    chk_val({31'h0, cpu_rst_n}, 32'h0);
    brownout_detect <= 1'b0;
    repeat (100) @(posedge ref_clk);
    chk_val({31'h0, cpu_rst_n}, 32'h0);
    por_ok <= 1'b1;
    run_reset(66, 80, 4'h8, 1'b1);
    $display("debug and brown-out done");
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, brownout_detect, wdt_timeout, stop_exec, dbg_frame_err, dbg_tx_collision} = '0;
    {pin_pull, dbg_low, avs_read, avs_write, gpio_low} = '0;
    por_ok = 1'b1;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    wake_pins = 8'h00;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    t_power();
    t_wdt();
    t_pin();
    t_stop();
    t_debug();
    stop_test();
  end
endmodule
